/* pes_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module pes_chk
  import pes_pkg::*;
#(
  parameter int   NUM_IRQ    = DEF_NUM_IRQ,
  parameter logic MULTI_CORE = 1'b0,
  localparam int  NE         = EXC_IRQ0 + NUM_IRQ,
  localparam int  NW         = $clog2(NE)
) (
  input wire logic            mclk_in,
  input wire logic            reset_n_in,
  input wire logic            nmi_line_in,
  input wire logic            entry_ack_in,
  input wire logic            halt_out,
  input wire logic            reset_fetch_out,
  input wire logic [VEC_W-1:0] reset_vec_addr_out,
  input wire logic            thread_mode_out,
  input wire logic            privileged_out,
  input wire logic            take_valid_out,
  input wire logic [NW-1:0]   take_num_out,
  input wire logic [VEC_W-1:0] take_vec_out,
  input wire logic            clear_local_tag_out,
  input wire logic            clear_global_tag_out,
  input wire logic [NE*2-1:0] exc_state_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  rst_hold_a: assert property (
    $rose(reset_n_in) |-> halt_out && !take_valid_out && exc_state_out == '0)
    else $error("core not held at reset release");
  boot_mode_a: assert property (
    $rose(reset_n_in) |=> reset_fetch_out && thread_mode_out && privileged_out)
    else $error("boot fetch or mode wrong");
  boot_vec_a: assert property (
    reset_fetch_out |-> reset_vec_addr_out == RESET_VEC_ADDR)
    else $error("boot vector address wrong");
  nmi_pend_a: assert property (
    !halt_out && nmi_line_in |=> exc_state_out[2*EXC_NMI])
    else $error("nmi line did not pend");
  nmi_offer_a: assert property (
    !halt_out && exc_state_out[2*EXC_NMI +: 2] == 2'h1
      |-> ##[0:3] take_valid_out && take_num_out == EXC_NMI)
    else $error("pending nmi not offered");
  accept_a: assert property (
    take_valid_out && entry_ack_in
      |=> exc_state_out[2*$past(take_num_out)+1] && !take_valid_out)
    else $error("accepted source not active");
  tag_clear_a: assert property (
    take_valid_out && entry_ack_in
      |=> clear_local_tag_out && clear_global_tag_out == MULTI_CORE)
    else $error("tags not cleared on entry");
  tag_cause_a: assert property (
    clear_local_tag_out |-> $past(take_valid_out && entry_ack_in))
    else $error("tag clear without entry");
  offer_vec_a: assert property (
    take_valid_out |-> exc_state_out[2*take_num_out]
      && take_vec_out == (VEC_W'(take_num_out) << VEC_SHIFT))
    else $error("offer not pending or vector wrong");
endmodule : pes_chk
`default_nettype wire

/* pes_core.sv */
`timescale 1ns/100ps
`default_nettype none
module pes_core
  import pes_pkg::*;
#(
  parameter int   NUM_IRQ    = DEF_NUM_IRQ,
  parameter logic MULTI_CORE = 1'b0,
  localparam int  NUM_EXC    = EXC_IRQ0 + NUM_IRQ,
  localparam int  NUM_W      = $clog2(NUM_EXC)
) (
  input  wire logic                  mclk_in,
  input  wire logic                  reset_n_in,
  input  wire logic                  reset_fetch_done_in,
  input  wire logic                  nmi_line_in,
  input  wire logic                  nmi_soft_set_in,
  input  wire logic [NUM_IRQ-1:0]    irq_line_in,
  input  wire logic [NUM_IRQ-1:0]    irq_soft_set_in,
  input  wire logic [NUM_IRQ-1:0]    irq_enable_in,
  input  wire logic [2:0]            sys_fault_en_in,
  input  wire logic [NUM_EXC*PRIO_W-1:0] exc_prio_in,
  input  wire logic                  entry_err_in,
  input  wire logic                  prot_unit_en_in,
  input  wire logic                  region_viol_in,
  input  wire logic                  xn_fetch_in,
  input  wire logic                  bus_err_in,
  input  wire logic                  undef_instr_in,
  input  wire logic                  unalign_illegal_in,
  input  wire logic                  bad_state_in,
  input  wire logic                  unalign_access_in,
  input  wire logic                  unalign_trap_en_in,
  input  wire logic                  div_zero_in,
  input  wire logic                  div_zero_trap_en_in,
  input  wire logic                  supervisor_call_in,
  input  wire logic                  deferred_service_set_in,
  input  wire logic                  tick_zero_in,
  input  wire logic                  tick_soft_set_in,
  input  wire logic                  entry_ack_in,
  input  wire logic                  ret_valid_in,
  input  wire logic [NUM_W-1:0]      ret_num_in,
  output logic                       halt_out,
  output logic                       reset_fetch_out,
  output logic [VEC_W-1:0]           reset_vec_addr_out,
  output logic                       thread_mode_out,
  output logic                       privileged_out,
  output logic                       take_valid_out,
  output logic [NUM_W-1:0]           take_num_out,
  output logic [VEC_W-1:0]           take_vec_out,
  output logic                       clear_local_tag_out,
  output logic                       clear_global_tag_out,
  output logic [NUM_EXC*2-1:0]       exc_state_out
);

  if (NUM_IRQ < 1 || NUM_IRQ > MAX_NUM_IRQ)
    $error("pes_core: NUM_IRQ out of range");

  function automatic logic is_impl(input int n);
    return n == EXC_NMI || n == EXC_HARD || n == EXC_MEM ||
           n == EXC_BUS || n == EXC_USAGE || n == EXC_SVC ||
           n == EXC_DEFER || n == EXC_TICK || n >= EXC_IRQ0;
  endfunction : is_impl

  pes_run_t                 run_q;
  logic                     halt_q;
  logic                     fetch_q;
  logic [VEC_W-1:0]         rvec_q;
  logic                     thread_q;
  logic                     priv_q;
  logic                     take_valid_q;
  logic [NUM_W-1:0]         take_num_q;
  logic [VEC_W-1:0]         take_vec_q;
  logic                     clr_local_q;
  logic                     clr_global_q;

  logic [NUM_EXC-1:0]       pend_w;
  logic [NUM_EXC-1:0]       act_w;
  logic [NUM_EXC-1:0]       en_w;
  logic [NUM_EXC-1:0]       ok_w;
  logic [NUM_EXC-1:0]       set_w;
  logic [NUM_EXC-1:0]       accept_w;
  logic [NUM_EXC-1:0]       retire_w;
  logic [NUM_EXC*RANK_W-1:0] rank_w;
  logic [RANK_W-1:0]        exec_rank;
  logic                     best_found;
  logic [NUM_W-1:0]         best_num;
  logic [RANK_W-1:0]        best_rank;
  logic                     running;
  logic                     accept_any;
  logic                     mem_evt;
  logic                     usage_evt;
  logic                     ret_bad;

  assign running = (run_q == RUN_GO);

  // Rank per source; fixed ones sit below every configurable value
  always_comb
  begin
    rank_w = '1;
    for (int n = 0; n < NUM_EXC; n++)
    begin
      if (n == EXC_NMI)
        rank_w[n*RANK_W +: RANK_W] = RANK_NMI;
      else if (n == EXC_HARD)
        rank_w[n*RANK_W +: RANK_W] = RANK_HARD;
      else if (is_impl(n))
        rank_w[n*RANK_W +: RANK_W] = RANK_CFG_BASE +
          RANK_W'(exc_prio_in[n*PRIO_W +: PRIO_W]);
      else
        rank_w[n*RANK_W +: RANK_W] = RANK_NONE;
    end
  end

  always_comb
  begin
    en_w = '0;
    en_w[EXC_NMI]   = 1'b1;
    en_w[EXC_HARD]  = 1'b1;
    en_w[EXC_MEM]   = sys_fault_en_in[0];
    en_w[EXC_BUS]   = sys_fault_en_in[1];
    en_w[EXC_USAGE] = sys_fault_en_in[2];
    en_w[EXC_SVC]   = 1'b1;
    en_w[EXC_DEFER] = 1'b1;
    en_w[EXC_TICK]  = 1'b1;
    en_w[NUM_EXC-1:EXC_IRQ0] = irq_enable_in;
  end

  // Execution priority is the most urgent active handler
  always_comb
  begin
    exec_rank = RANK_NONE;
    for (int n = 0; n < NUM_EXC; n++)
    begin
      if (act_w[n] && rank_w[n*RANK_W +: RANK_W] < exec_rank)
        exec_rank = rank_w[n*RANK_W +: RANK_W];
    end
  end

  // A source may be taken only if strictly more urgent than now
  always_comb
  begin
    for (int n = 0; n < NUM_EXC; n++)
      ok_w[n] = en_w[n] && (rank_w[n*RANK_W +: RANK_W] < exec_rank);
  end

  // Out-of-range return number counts as a bad return
  assign ret_bad   = ret_valid_in &&
                     (ret_num_in >= NUM_EXC || !act_w[ret_num_in]);
  assign mem_evt   = (region_viol_in & prot_unit_en_in) |
                     xn_fetch_in;
  assign usage_evt = undef_instr_in | unalign_illegal_in | bad_state_in |
                     ret_bad |
                     (unalign_access_in & unalign_trap_en_in) |
                     (div_zero_in & div_zero_trap_en_in);

  // Synchronous faults that cannot be taken escalate to hard fault
  always_comb
  begin
    set_w = '0;
    if (running)
    begin
      set_w[EXC_NMI]   = nmi_line_in | nmi_soft_set_in;
      set_w[EXC_MEM]   = mem_evt & ok_w[EXC_MEM];
      set_w[EXC_BUS]   = bus_err_in & ok_w[EXC_BUS];
      set_w[EXC_USAGE] = usage_evt & ok_w[EXC_USAGE];
      set_w[EXC_SVC]   = supervisor_call_in & ok_w[EXC_SVC];
      set_w[EXC_HARD]  = entry_err_in |
                         (mem_evt & ~ok_w[EXC_MEM]) |
                         (bus_err_in & ~ok_w[EXC_BUS]) |
                         (usage_evt & ~ok_w[EXC_USAGE]) |
                         (supervisor_call_in & ~ok_w[EXC_SVC]);
      set_w[EXC_DEFER] = deferred_service_set_in;
      set_w[EXC_TICK]  = tick_zero_in | tick_soft_set_in;
      set_w[NUM_EXC-1:EXC_IRQ0] = irq_line_in | irq_soft_set_in;
    end
  end

  assign accept_any = entry_ack_in && take_valid_q;

  always_comb
  begin
    accept_w = '0;
    retire_w = '0;
    if (accept_any)
      accept_w[take_num_q] = 1'b1;
    if (ret_valid_in)
      retire_w[ret_num_in] = 1'b1;
  end

  for (genvar g = 0; g < NUM_EXC; g++)
  begin : g_src
    if (is_impl(g))
    begin : g_on
      pes_exc_state_t st;
      pes_slot u_slot (
        .mclk_in    (mclk_in),
        .reset_n_in (reset_n_in),
        .set_in     (set_w[g]),
        .accept_in  (accept_w[g]),
        .retire_in  (retire_w[g]),
        .state_out  (st)
      );
      assign pend_w[g] = st[0];
      assign act_w[g]  = st[1];
    end
    else
    begin : g_off
      assign pend_w[g] = 1'b0;
      assign act_w[g]  = 1'b0;
    end
    assign exc_state_out[g*2 +: 2] = {act_w[g], pend_w[g]};
  end

  pes_pick #(
    .N  (NUM_EXC),
    .NW (NUM_W),
    .RW (RANK_W)
  ) u_pick (
    .cand_in   (pend_w & en_w),
    .rank_in   (rank_w),
    .found_out (best_found),
    .num_out   (best_num),
    .rank_out  (best_rank)
  );

  // Reset sequencing: halt, fetch reset vector, then run
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      run_q   <= RUN_HALT;
      halt_q  <= 1'b1;
      fetch_q <= 1'b0;
      rvec_q  <= RESET_VEC_ADDR;
    end
    else
    begin
      case (run_q)
        RUN_HALT:
        begin
          run_q   <= RUN_FETCH;
          fetch_q <= 1'b1;
        end
        RUN_FETCH:
        begin
          if (reset_fetch_done_in)
          begin
            run_q   <= RUN_GO;
            fetch_q <= 1'b0;
            halt_q  <= 1'b0;
          end
        end
        RUN_GO:
        begin
          halt_q <= 1'b0;
        end
        default:
        begin
          run_q  <= RUN_HALT;
          halt_q <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      thread_q <= THREAD_RESET;
      priv_q   <= PRIV_RESET;
    end
    else
    begin
      thread_q <= ~|((act_w | accept_w) & ~retire_w);
      priv_q   <= PRIV_RESET;
    end
  end

  // Offer is dropped in the ack cycle so a stale choice is never reissued
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      take_valid_q <= 1'b0;
      take_num_q   <= '0;
      take_vec_q   <= VEC_RESET_VAL;
    end
    else
    begin
      take_valid_q <= running && best_found && !accept_any &&
                      (best_rank < exec_rank);
      take_num_q   <= best_num;
      take_vec_q   <= VEC_W'(best_num) << VEC_SHIFT;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      clr_local_q  <= 1'b0;
      clr_global_q <= 1'b0;
    end
    else
    begin
      clr_local_q  <= accept_any;
      clr_global_q <= accept_any & MULTI_CORE;
    end
  end

  assign halt_out             = halt_q;
  assign reset_fetch_out      = fetch_q;
  assign reset_vec_addr_out   = rvec_q;
  assign thread_mode_out      = thread_q;
  assign privileged_out       = priv_q;
  assign take_valid_out       = take_valid_q;
  assign take_num_out         = take_num_q;
  assign take_vec_out         = take_vec_q;
  assign clear_local_tag_out  = clr_local_q;
  assign clear_global_tag_out = clr_global_q;

endmodule : pes_core
`default_nettype wire

/* pes_pick.sv */
`timescale 1ns/100ps
`default_nettype none
module pes_pick #(
  parameter int N  = 46,
  parameter int NW = 6,
  parameter int RW = 5
) (
  input  wire logic [N-1:0]    cand_in,
  input  wire logic [N*RW-1:0] rank_in,
  output logic                 found_out,
  output logic [NW-1:0]        num_out,
  output logic [RW-1:0]        rank_out
);

  if (N < 1 || NW < $clog2(N) || RW < 1)
    $error("pes_pick: parameters out of range");

  always_comb
  begin
    found_out = 1'b0;
    num_out   = '0;
    rank_out  = '1;
    // Strict compare keeps the lowest number on a tie
    for (int i = 0; i < N; i++)
    begin
      if (cand_in[i] && (!found_out || rank_in[i*RW +: RW] < rank_out))
      begin
        found_out = 1'b1;
        num_out   = NW'(i);
        rank_out  = rank_in[i*RW +: RW];
      end
    end
  end

endmodule : pes_pick
`default_nettype wire

/* pes_pipe_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pes_pipe_model #(
  parameter int FETCH_LAT = 3
) (
  input  wire logic       mclk_in,
  input  wire logic       reset_n_in,
  input  wire logic       fetch_req_in,
  input  wire logic       take_valid_in,
  input  wire logic       ack_on_in,
  input  wire logic [3:0] ack_wait_in,
  output logic            fetch_done_out,
  output logic            ack_out
);
  int fetch_cnt = 0;
  int wait_cnt  = 0;

  initial fetch_done_out = 1'b0;
  initial ack_out = 1'b0;

  // Acts after the falling edge; ack held across exactly one rising edge
  always @(negedge mclk_in)
  begin
    fetch_cnt = (reset_n_in && fetch_req_in) ? fetch_cnt + 1 : 0;
    fetch_done_out = (fetch_cnt > FETCH_LAT);
    if (ack_out || !reset_n_in || !take_valid_in || !ack_on_in)
    begin
      ack_out = 1'b0;
      wait_cnt = 0;
    end
    else if (wait_cnt >= ack_wait_in)
      ack_out = 1'b1;
    else
      wait_cnt++;
  end
endmodule : pes_pipe_model
`default_nettype wire

/* pes_pkg.sv */
`default_nettype none
package pes_pkg;

  // Exception numbers of the fixed sources; interrupts start at EXC_IRQ0
  localparam int EXC_NMI   = 2;
  localparam int EXC_HARD  = 3;
  localparam int EXC_MEM   = 4;
  localparam int EXC_BUS   = 5;
  localparam int EXC_USAGE = 6;
  localparam int EXC_SVC   = 11;
  localparam int EXC_DEFER = 14;
  localparam int EXC_TICK  = 15;
  localparam int EXC_IRQ0  = 16;

  localparam int DEF_NUM_IRQ = 30;
  localparam int MAX_NUM_IRQ = 240;

  // Configurable priority 0-15, lower value is more urgent
  localparam int PRIO_W = 4;

  // Internal rank: fixed priorities -2/-1 map below configurable 0
  localparam int RANK_W = 5;
  localparam logic [RANK_W-1:0] RANK_NMI      = 5'h01;
  localparam logic [RANK_W-1:0] RANK_HARD     = 5'h02;
  localparam logic [RANK_W-1:0] RANK_CFG_BASE = 5'h03;
  localparam logic [RANK_W-1:0] RANK_NONE     = 5'h1F;

  localparam int VEC_W     = 32;
  localparam int VEC_SHIFT = 2;
  localparam logic [VEC_W-1:0] RESET_VEC_ADDR = 32'h00000004;
  localparam logic [VEC_W-1:0] VEC_RESET_VAL  = 32'h00000000;

  localparam logic PRIV_RESET   = 1'b1;
  localparam logic THREAD_RESET = 1'b1;

  typedef enum logic [1:0] {
    EXC_INACTIVE       = 2'b00,
    EXC_PENDING        = 2'b01,
    EXC_ACTIVE         = 2'b10,
    EXC_ACTIVE_PENDING = 2'b11
  } pes_exc_state_t;

  typedef enum logic [1:0] {
    RUN_HALT  = 2'b00,
    RUN_FETCH = 2'b01,
    RUN_GO    = 2'b10
  } pes_run_t;

endpackage : pes_pkg
`default_nettype wire

/* pes_slot.sv */
`timescale 1ns/100ps
`default_nettype none
module pes_slot
  import pes_pkg::*;
(
  input  wire logic     mclk_in,
  input  wire logic     reset_n_in,
  input  wire logic     set_in,
  input  wire logic     accept_in,
  input  wire logic     retire_in,
  output pes_exc_state_t state_out
);

  pes_exc_state_t state_q;
  logic           pend_d;
  logic           act_d;

  // New request wins over the clear done by acceptance
  assign pend_d = set_in | (state_q[0] & ~accept_in);
  assign act_d  = accept_in | (state_q[1] & ~retire_in);

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      state_q <= EXC_INACTIVE;
    else
      state_q <= pes_exc_state_t'({act_d, pend_d});
  end

  assign state_out = state_q;

endmodule : pes_slot
`default_nettype wire

/* tb_processor_exception_state_unit.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_processor_exception_state_unit
  import pes_pkg::*;
;
  localparam int NI = 2;
  localparam int NE = EXC_IRQ0 + NI;
  localparam int NW = $clog2(NE);
  logic                 mclk_in    = 1'b0;
  logic                 reset_n_in = 1'b0;
  logic [18:0]          cause      = '0;
  logic [2:0]           cfg        = 3'h7;
  logic [NE*PRIO_W-1:0] prio       = '0;
  logic                 ack_on     = 1'b0;
  logic [3:0]           ack_wait   = 4'h0;
  logic                 ret_valid  = 1'b0;
  logic [NW-1:0]        ret_num    = '0;
  logic                 done, ack, halt, rfetch, thr, priv, tv, clt, cgt;
  logic [NW-1:0]        tnum;
  logic [VEC_W-1:0]     rvec, tvec;
  logic [NE*2-1:0]      st;
  int                   n_errors   = 0;
  int                   n_checks   = 0;

  always #2 mclk_in = ~mclk_in;

  pes_core #(.NUM_IRQ(NI), .MULTI_CORE(1'b1)) pes_core_inst (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .reset_fetch_done_in(done), .nmi_line_in(cause[0]),
    .nmi_soft_set_in(cause[1]), .irq_line_in(cause[16:15]),
    .irq_soft_set_in(cause[18:17]), .irq_enable_in(2'h3),
    .sys_fault_en_in({3{cfg[0]}}), .exc_prio_in(prio),
    .entry_err_in(cause[2]), .prot_unit_en_in(cfg[2]),
    .region_viol_in(cause[3]), .xn_fetch_in(cause[4]),
    .bus_err_in(cause[5]), .undef_instr_in(cause[6]),
    .unalign_illegal_in(cause[7]), .bad_state_in(cause[8]),
    .unalign_access_in(cause[9]), .unalign_trap_en_in(cfg[1]),
    .div_zero_in(cause[10]), .div_zero_trap_en_in(cfg[1]),
    .supervisor_call_in(cause[11]), .deferred_service_set_in(cause[12]),
    .tick_zero_in(cause[13]), .tick_soft_set_in(cause[14]),
    .entry_ack_in(ack), .ret_valid_in(ret_valid), .ret_num_in(ret_num),
    .halt_out(halt), .reset_fetch_out(rfetch), .reset_vec_addr_out(rvec),
    .thread_mode_out(thr), .privileged_out(priv), .take_valid_out(tv),
    .take_num_out(tnum), .take_vec_out(tvec),
    .clear_local_tag_out(clt), .clear_global_tag_out(cgt),
    .exc_state_out(st));

  pes_pipe_model pes_pipe_model_inst (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .fetch_req_in(rfetch),
    .take_valid_in(tv), .ack_on_in(ack_on), .ack_wait_in(ack_wait),
    .fetch_done_out(done), .ack_out(ack));

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [63:0] exp,
                     input logic [63:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge mclk_in);
  endtask : tick

  task automatic pulse(input logic [18:0] m);
    cause = m;
    tick(1);
    cause = '0;
  endtask : pulse

  task automatic do_reset();
    int i;
    reset_n_in = 1'b0;
    tick(20);
    chk("halt and offer", 2'h2, {halt, tv});
    chk("state in reset", 0, st);
    reset_n_in = 1'b1;
    for (i = 0; i < 20 && halt !== 1'b0; i++)
      tick(1);
    chk("halt after boot", 0, halt);
    chk("thread priv", 2'h3, {thr, priv});
    chk("boot vector", RESET_VEC_ADDR, rvec);
    if (halt !== 1'b0)
      complete_run();
  endtask : do_reset

  task automatic wait_st(input int n, input logic [1:0] exp);
    int i;
    for (i = 0; i < 20 && st[2*n +: 2] !== exp; i++)
      tick(1);
    chk($sformatf("state of %0d", n), exp, st[2*n +: 2]);
    if (st[2*n +: 2] !== exp)
      complete_run();
  endtask : wait_st

  // Each case from a clean reset, so the whole state word must match
  task automatic t_sources();
    int src[21] = '{0, 1, 2, 3, 3, 4, 5, 6, 7, 8, 9, 9, 10, 10, 11, 12,
                    13, 14, 5, 15, 18};
    int cf[21]  = '{7, 7, 7, 7, 3, 3, 7, 7, 7, 7, 7, 5, 7, 5, 7, 7,
                    7, 7, 6, 7, 7};
    int ex[21]  = '{2, 2, 3, 4, -1, 4, 5, 6, 6, 6, 6, -1, 6, -1, 11, 14,
                    15, 15, 3, 16, 17};
    int k;
    logic [63:0] exp;
    for (k = 0; k < 21; k++)
    begin
      cfg = 3'(cf[k]);
      do_reset();
      pulse(19'h1 << src[k]);
      tick(1);
      exp = (ex[k] < 0) ? 64'h0 : (64'h1 << (2 * ex[k]));
      chk($sformatf("source %0d", src[k]), exp, st);
    end
    cfg = 3'h7;
    $display("t_sources done");
  endtask : t_sources

  task automatic t_nest();
    prio = '0;
    prio[16*PRIO_W +: 8] = 8'h55;
    prio[15*PRIO_W +: 4] = 4'h2;
    ack_wait = 4'h3;
    do_reset();
    pulse(19'h18000);
    tick(2);
    chk("tie offer", {1'b1, NW'(16)}, {tv, tnum});
    chk("tie vector", 32'h00000040, tvec);
    ack_on = 1'b1;
    wait_st(16, 2'h2);
    chk("tag clear", 2'h3, {clt, cgt});
    tick(10);
    chk("equal prio", 2'h1, st[35:34]);
    ack_wait = 4'h0;
    pulse(19'h04000);
    wait_st(15, 2'h2);
    pulse(19'h08000);
    wait_st(16, 2'h3);
    ret_num = NW'(15);
    ret_valid = 1'b1;
    tick(1);
    ret_valid = 1'b0;
    wait_st(15, 2'h0);
    // Returning from a handler that is not active is a usage fault
    ret_valid = 1'b1;
    tick(1);
    ret_valid = 1'b0;
    wait_st(6, 2'h2);
    pulse(19'h00001);
    wait_st(2, 2'h2);
    chk("nested active", 4'h7, st[35:32]);
    chk("thread in handler", 0, thr);
    ack_on = 1'b0;
    $display("t_nest done");
  endtask : t_nest

  initial
  begin
    do_reset();
    t_sources();
    t_nest();
    complete_run();
  end
endmodule : tb_processor_exception_state_unit

bind pes_core pes_chk #(.NUM_IRQ(NUM_IRQ), .MULTI_CORE(MULTI_CORE))
  pes_chk_inst (
  .mclk_in(mclk_in), .reset_n_in(reset_n_in), .nmi_line_in(nmi_line_in),
  .entry_ack_in(entry_ack_in), .halt_out(halt_out),
  .reset_fetch_out(reset_fetch_out),
  .reset_vec_addr_out(reset_vec_addr_out),
  .thread_mode_out(thread_mode_out), .privileged_out(privileged_out),
  .take_valid_out(take_valid_out), .take_num_out(take_num_out),
  .take_vec_out(take_vec_out), .clear_local_tag_out(clear_local_tag_out),
  .clear_global_tag_out(clear_global_tag_out),
  .exc_state_out(exc_state_out));
`default_nettype wire
